//--- logic/ppe_pkg.sv
// Package for the port pins and program entry block.
// Assumes one core clock; all pin levels arrive unsynchronised.
package ppe_pkg;
  // ==========================================================
  // Port widths
  localparam int OD_W    = 5;     // Open-drain / pulled-up port
  localparam int P_W     = 8;     // Byte-wide ports
  localparam int ADDR_W  = 11;    // Assembled memory address
  localparam int HI_W    = 3;     // Bits used from the high address byte
  localparam int CH_W    = 3;     // Converter channel select width
  localparam int AN_N    = 5;     // Number of analog input pins
  // ==========================================================
  // Reset and entry sequence
  localparam int MC_CLKS     = 12;   // Oscillator clocks per machine cycle
  localparam int RST_MC      = 2;    // Machine cycles of high reset
  localparam int RST_CLKS    = RST_MC * MC_CLKS;
  localparam int CODE_W      = 10;   // Serial entry code length
  localparam logic [9:0] ENTRY_CODE_DEF = 10'h2A5; // Arbitrary default
  // ==========================================================
  // Values after reset
  localparam logic [4:0] OD_LATCH_RST = 5'h1F;
  localparam logic [7:0] P_LATCH_RST  = 8'hFF;
  // Programming-state machine
  typedef enum logic [1:0] {PPE_RUN, PPE_SHIFT, PPE_PROG} ppe_state_t;
endpackage

//--- logic/ppe_top.sv
// Pin-level logic of the ports, the reset pin and programming entry.
// Assumes the testbench resolves each pin wire from the enable signals.
`timescale 1ns/10ps
module ppe_top
  import ppe_pkg::*;
#(
  parameter logic [9:0] ENTRY_CODE = ENTRY_CODE_DEF  // Arbitrary value
) (
  // Clock and core reset
  input  wire logic              i_mclk,
  input  wire logic              i_rst_b,
  // Reset pin, active high, also carries the entry code
  input  wire logic              i_rst_pin,
  // Core-side port latches and controls
  input  wire logic [OD_W-1:0]   i_od_latch,
  input  wire logic [P_W-1:0]    i_an_latch,
  input  wire logic [P_W-1:0]    i_ad_latch,
  input  wire logic              i_i2c_en,
  input  wire logic              i_scl_drv,
  input  wire logic              i_sda_drv,
  input  wire logic              i_converter_enable_bit,
  input  wire logic [CH_W-1:0]   i_conv_chan,
  // Memory byte for verify
  input  wire logic [P_W-1:0]    i_mem_rdata,
  // Pin inputs
  input  wire logic [OD_W-1:0]   i_od_pin,
  input  wire logic [P_W-1:0]    i_an_pin,
  input  wire logic [P_W-1:0]    i_ad_pin,
  // Pin outputs and enables (enable low drives)
  output logic      [OD_W-1:0]   o_od_pin,
  output logic      [OD_W-1:0]   o_od_oe_b,
  output logic      [P_W-1:0]    o_an_pin,
  output logic      [P_W-1:0]    o_an_oe_b,
  output logic      [P_W-1:0]    o_ad_pin,
  output logic      [P_W-1:0]    o_ad_oe_b,
  // Core-side reads and status
  output logic      [OD_W-1:0]   o_od_read,
  output logic      [P_W-1:0]    o_an_read,
  output logic      [P_W-1:0]    o_ad_read,
  output logic                   o_core_rst,
  output logic                   o_prog_state,
  output logic                   o_verify_mode,
  output logic      [ADDR_W-1:0] o_prog_addr,
  output logic      [P_W-1:0]    o_prog_wdata
);
  // ==========================================================
  // Input synchronisers
  logic [OD_W-1:0] od_s1, od_s2;   // Open-drain port pins
  logic [P_W-1:0]  an_s1, an_s2;   // Analog port pins
  logic [P_W-1:0]  ad_s1, ad_s2;   // Address port pins
  logic            rp_s1, rp_s2;   // Reset pin

  // Two flops per pin before any logic looks at it
  always_ff @(posedge i_mclk) begin
    od_s1 <= i_od_pin;
    od_s2 <= od_s1;
    an_s1 <= i_an_pin;
    an_s2 <= an_s1;
    ad_s1 <= i_ad_pin;
    ad_s2 <= ad_s1;
    rp_s1 <= i_rst_pin;
    rp_s2 <= rp_s1;
  end

  // ==========================================================
  // Reset pin filter and entry state
  logic [4:0]      rst_cnt;        // Clocks of continuous high reset
  logic            full_rst;       // Reset held long enough
  logic [3:0]      bit_cnt;        // Code bits taken
  logic [9:0]      code_sr;        // Code shift register
  ppe_state_t      state;          // Entry state

  // Count high reset; a short glitch does not reset the device
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b || !rp_s2) begin
      rst_cnt  <= 5'h00;
      full_rst <= 1'b0;
    end else if (rst_cnt < 5'(RST_CLKS - 1)) begin
      rst_cnt <= rst_cnt + 5'h01;
    end else begin
      full_rst <= 1'b1;
    end
  end

  // Entry sequence: after reset release, bits shift in one per clock
  // Limitation: one bit per core clock, the programmer keeps pace
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b || full_rst) begin
      state   <= full_rst ? PPE_SHIFT : PPE_RUN;
      bit_cnt <= 4'h0;
      code_sr <= 10'h000;
    end else begin
      case (state)
        PPE_SHIFT: begin
          code_sr <= {rp_s2, code_sr[9:1]};
          bit_cnt <= bit_cnt + 4'h1;
          if (bit_cnt == 4'(CODE_W - 1)) begin
            state <= ({rp_s2, code_sr[9:1]} == ENTRY_CODE) ? PPE_PROG : PPE_RUN;
          end
        end
        PPE_PROG: state <= PPE_PROG;
        PPE_RUN:  state <= PPE_RUN;
        default:  state <= PPE_RUN;
      endcase
    end
  end

  // ==========================================================
  // Programming datapath
  logic prog;                       // Programming state active
  assign prog = (state == PPE_PROG);

  // Address bytes and write data captured from synchronised pins
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      o_prog_addr   <= '0;
      o_prog_wdata  <= 8'h00;
      o_verify_mode <= 1'b0;
    end else if (prog) begin
      o_verify_mode <= od_s2[1];
      if (od_s2[0]) begin
        o_prog_addr[ADDR_W-1:P_W] <= ad_s2[HI_W-1:0];
      end else begin
        o_prog_addr[P_W-1:0] <= ad_s2;
      end
      o_prog_wdata <= an_s2;
    end
  end

  // ==========================================================
  // Pin drivers
  logic [OD_W-1:0] od_low;          // Open-drain port pulled low
  logic [P_W-1:0]  an_mask;         // Analog pins barred from output

  always_comb begin
    od_low = ~i_od_latch;
    if (i_i2c_en) begin
      od_low[0] = ~i_od_latch[0] | ~i_scl_drv;
      od_low[1] = ~i_od_latch[1] | ~i_sda_drv;
    end
    an_mask = '0;
    if (i_converter_enable_bit) begin
      an_mask[AN_N-1:0] = '1;
    end
  end

  // Registered outputs; one drives low, a pulled-up one floats high
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b || full_rst) begin
      o_od_pin  <= '0;
      o_od_oe_b <= '1;
      o_an_pin  <= '0;
      o_an_oe_b <= '1;
      o_ad_pin  <= '0;
      o_ad_oe_b <= '1;
    end else if (prog) begin
      o_od_oe_b <= '1;
      o_ad_oe_b <= '1;
      o_ad_pin  <= '0;
      o_od_pin  <= '0;
      o_an_pin  <= i_mem_rdata;
      o_an_oe_b <= od_s2[1] ? 8'h00 : 8'hFF;
    end else begin
      o_od_pin  <= '0;
      o_od_oe_b <= ~od_low;
      o_an_pin  <= '0;
      o_an_oe_b <= i_an_latch | an_mask;
      o_ad_pin  <= '0;
      o_ad_oe_b <= i_ad_latch;
    end
  end

  // ==========================================================
  // Pin reads and status
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      o_od_read    <= '1;
      o_an_read    <= '1;
      o_ad_read    <= '1;
      o_core_rst   <= 1'b1;
      o_prog_state <= 1'b0;
    end else begin
      o_od_read    <= od_s2;
      o_an_read    <= an_s2;
      if (i_converter_enable_bit && (i_conv_chan < 3'(AN_N))) begin
        o_an_read[i_conv_chan] <= 1'b1;
      end
      o_ad_read    <= ad_s2;
      o_core_rst   <= full_rst || (state != PPE_RUN);
      o_prog_state <= prog;
    end
  end

  // ==========================================================
  // Assertions
  a_reset_full: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    full_rst |=> o_core_rst)
    else $error("core reset not raised by long reset");
  a_od_drive: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (!prog && !full_rst && !i_i2c_en) |=> (o_od_oe_b == $past(i_od_latch)))
    else $error("open-drain enable mismatch");
  a_i2c_wand: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (!prog && !full_rst && i_i2c_en && !i_scl_drv) |=> !o_od_oe_b[0])
    else $error("scl not pulled low");
  a_an_block: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (!prog && i_converter_enable_bit) |=> (o_an_oe_b[4:0] == 5'h1F))
    else $error("analog pin driven with converter on");
  a_chan_one: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (i_converter_enable_bit && i_conv_chan == 3'h2) |=> o_an_read[2])
    else $error("selected channel not read as one");
  a_prog_hold: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (prog && !full_rst) |=> prog)
    else $error("left programming state without reset");
  a_verify_out: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (prog && !full_rst && od_s2[1]) |=> (o_an_oe_b == 8'h00))
    else $error("verify byte not driven");
  a_addr_low: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (prog && !od_s2[0]) |=> (o_prog_addr[7:0] == $past(ad_s2)))
    else $error("low address byte not taken");
  c_entry: cover property (@(posedge i_mclk) state == PPE_SHIFT ##10 prog);
  c_verify: cover property (@(posedge i_mclk) prog && o_verify_mode);
  c_i2c: cover property (@(posedge i_mclk) i_i2c_en && !i_sda_drv);
endmodule

//--- tb/ppe_pin_model.sv
// Pin model: pull-ups, outside drivers pulling low, program memory.
// Assumes the block drives its pin value only where its enable is low.
`timescale 1ns/10ps
module ppe_pin_model
  import ppe_pkg::*;
(
  // Block enables and address
  input  wire logic [OD_W-1:0]   i_od_oe_b,
  input  wire logic [P_W-1:0]    i_an_oe_b,
  input  wire logic [P_W-1:0]    i_ad_oe_b,
  input  wire logic [ADDR_W-1:0] i_addr,
  // Block pin values, seen only where the enable is low
  input  wire logic [OD_W-1:0]   i_od_drv,
  input  wire logic [P_W-1:0]    i_an_drv,
  input  wire logic [P_W-1:0]    i_ad_drv,
  // Outside parties pulling low
  input  wire logic [OD_W-1:0]   i_od_low,
  input  wire logic [P_W-1:0]    i_an_low,
  input  wire logic [P_W-1:0]    i_ad_low,
  // Resolved pin levels and memory byte
  output logic      [OD_W-1:0]   o_od,
  output logic      [P_W-1:0]    o_an,
  output logic      [P_W-1:0]    o_ad,
  output logic      [P_W-1:0]    o_mem
);
  // ==========================================================
  // Driven pins show the block's value; released ones float to the pull-up
  // unless an outside party pulls them low
  assign o_od = (~i_od_oe_b & i_od_drv) | (i_od_oe_b & ~i_od_low);
  assign o_an = (~i_an_oe_b & i_an_drv) | (i_an_oe_b & ~i_an_low);
  assign o_ad = (~i_ad_oe_b & i_ad_drv) | (i_ad_oe_b & ~i_ad_low);
  // Byte mixes both address halves so a wrong half shows
  assign o_mem = i_addr[7:0] ^ {5'h00, i_addr[10:8]};
endmodule

//--- tb/tb.sv
// Testbench for the port pins and program entry block.
// Assumes pin levels come from the pin model with pull-ups.
`timescale 1ns/10ps
module tb;
  import ppe_pkg::*;
  // ==========================================================
  // Signals
  logic              clk, rst_b, rst_pin, i2c_en, scl, sda, cen;
  logic [OD_W-1:0]   od_lat, od_low, od_oe_b, od_pin, od_rd;
  logic [P_W-1:0]    an_lat, an_low, an_oe_b, an_pin, an_rd, mem, wdata;
  logic [P_W-1:0]    ad_lat, ad_low, ad_oe_b, ad_pin, ad_rd;
  logic [OD_W-1:0]   od_drv;
  logic [P_W-1:0]    an_drv, ad_drv;
  logic [CH_W-1:0]   chan;
  logic [ADDR_W-1:0] addr;
  logic              core_rst, prog, verify;
  int                miscompares, n_tests;
  // ==========================================================
  // Design and far side
  ppe_top DUT (.i_mclk(clk), .i_rst_b(rst_b), .i_rst_pin(rst_pin),
    .i_od_latch(od_lat), .i_an_latch(an_lat), .i_ad_latch(ad_lat),
    .i_i2c_en(i2c_en), .i_scl_drv(scl), .i_sda_drv(sda),
    .i_converter_enable_bit(cen), .i_conv_chan(chan), .i_mem_rdata(mem),
    .i_od_pin(od_pin), .i_an_pin(an_pin), .i_ad_pin(ad_pin),
    .o_od_pin(od_drv), .o_od_oe_b(od_oe_b), .o_an_pin(an_drv),
    .o_an_oe_b(an_oe_b), .o_ad_pin(ad_drv), .o_ad_oe_b(ad_oe_b),
    .o_od_read(od_rd), .o_an_read(an_rd),
    .o_ad_read(ad_rd), .o_core_rst(core_rst), .o_prog_state(prog),
    .o_verify_mode(verify), .o_prog_addr(addr), .o_prog_wdata(wdata));
  ppe_pin_model u_pins (.i_od_oe_b(od_oe_b), .i_an_oe_b(an_oe_b),
    .i_ad_oe_b(ad_oe_b), .i_addr(addr), .i_od_drv(od_drv),
    .i_an_drv(an_drv), .i_ad_drv(ad_drv), .i_od_low(od_low),
    .i_an_low(an_low), .i_ad_low(ad_low), .o_od(od_pin), .o_an(an_pin),
    .o_ad(ad_pin), .o_mem(mem));
  // ==========================================================
  // Helpers
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Pins pass two sync flops and a register, so allow margin
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic complete_run;
    if (miscompares == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_od;
    @(posedge clk) od_lat <= 5'h0A;
    wt(4);
    chk(od_oe_b, 5'h0A);
    @(posedge clk) od_low <= 5'h08;
    wt(4);
    chk(od_rd, 5'h02);
  endtask
  task automatic t_i2c;
    @(posedge clk) od_low <= 5'h00;
    od_lat <= 5'h1F;
    i2c_en <= 1'b1;
    wt(4);
    chk(od_oe_b, 5'h1C);
    chk(od_rd, 5'h1C);
    @(posedge clk) scl <= 1'b1;
    sda <= 1'b1;
    od_lat <= 5'h1E;
    wt(4);
    chk(od_oe_b, 5'h1E);
  endtask
  task automatic t_ports;
    @(posedge clk) an_lat <= 8'h5A;
    ad_lat <= 8'hC3;
    wt(4);
    chk(an_rd, 8'h5A);
    chk(ad_rd, 8'hC3);
    @(posedge clk) cen <= 1'b1;
    chan <= 3'h2;
    an_lat <= 8'h00;
    an_low <= 8'h06;
    wt(4);
    chk(an_oe_b, 8'h1F);
    chk(an_rd, 8'h1D);
  endtask
  task automatic t_entry(input logic [9:0] code, input logic exp);
    @(posedge clk) rst_pin <= 1'b1;
    repeat (26) @(posedge clk);
    // One low clock ends the long reset before the first code bit
    rst_pin <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < CODE_W; i++) begin
      rst_pin <= code[i];
      @(posedge clk);
    end
    rst_pin <= 1'b0;
    wt(6);
    chk(prog, exp);
    chk(core_rst, exp);
  endtask
  task automatic t_prog;
    @(posedge clk) cen <= 1'b0;
    an_low <= ~8'h96;
    ad_lat <= 8'h00;
    ad_low <= ~8'h34;
    od_low <= 5'h03;
    // Select syncs in, enables turn, then the byte syncs back
    wt(6);
    chk(ad_oe_b, 8'hFF);
    chk({verify, wdata}, 9'h096);
    @(posedge clk) an_low <= 8'h00;
    ad_low <= ~8'hFD;
    od_low <= 5'h00;
    wt(5);
    chk(addr, 11'h534);
    chk({verify, an_pin}, 9'h131);
    chk(an_oe_b, 8'h00);
    @(posedge clk) rst_b <= 1'b0;
    @(posedge clk) rst_b <= 1'b1;
    wt(2);
    chk(prog, 1'b0);
  endtask
  // ==========================================================
  // Clock, main sequence and watchdog
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    {rst_b, rst_pin, i2c_en, scl, sda, cen, chan} = '0;
    {od_lat, od_low, an_lat, an_low, ad_lat, ad_low} = '0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    t_od;
    t_i2c;
    t_ports;
    t_entry(~ENTRY_CODE_DEF, 1'b0);
    t_entry(ENTRY_CODE_DEF, 1'b1);
    t_prog;
    complete_run;
  end
  // Whole run needs under two hundred cycles
  initial begin
    repeat (3000) @(posedge clk);
    miscompares++;
    complete_run;
  end
endmodule
